/* common/mri_pkg.sv */
// Package with constants and types for the multiplexed readout integrator.
package mri_pkg;
  // Default number of slots and weight units.
  localparam int MRI_UNITS = 16;
  // Stored weight length in samples after upload.
  localparam int MRI_WEIGHT_LEN = 4096;
  // Sample width of every real or imaginary part.
  localparam int MRI_SAMPLE_W = 16;
  // Accumulator width.
  localparam int MRI_ACC_W = 48;
  // Sample period in ns and shortest pulse in ns.
  localparam int MRI_PERIOD_NS = 10;
  localparam int MRI_MIN_PULSE_NS = 2;
  // Shortest pulse in cycles, rounded up and at least one.
  localparam int MRI_MIN_PULSE_CYC = (MRI_MIN_PULSE_NS + MRI_PERIOD_NS - 1)
    / MRI_PERIOD_NS;
  // Discrimination modes.
  typedef enum logic {MRI_TWO_STATE, MRI_MULTI_STATE} mri_disc_t;
  // Integration state machine.
  typedef enum logic [1:0] {MRI_IDLE, MRI_RUN, MRI_DONE} mri_state_t;
endpackage : mri_pkg

/* logic/mri_integrator.sv */
// Readout datapath: waveform sum, weighted integration, discrimination, PSD.
`timescale 1ns/10ps
module mri_integrator
  import mri_pkg::*;
#(
  parameter int UNITS = MRI_UNITS,
  parameter int WLEN = MRI_WEIGHT_LEN,
  parameter int SW = MRI_SAMPLE_W,
  parameter int AW = MRI_ACC_W
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Waveform upload port: one complex sample at a time.
  input wire logic wave_wr,
  input wire logic [$clog2(UNITS)-1:0] wave_slot,
  input wire logic signed [SW-1:0] wave_re,
  input wire logic signed [SW-1:0] wave_im,
  input wire logic wave_clear,
  // Weight upload port.
  input wire logic wt_wr,
  input wire logic [$clog2(UNITS)-1:0] wt_unit,
  input wire logic [$clog2(WLEN)-1:0] wt_addr,
  input wire logic signed [SW-1:0] wt_re,
  input wire logic signed [SW-1:0] wt_im,
  input wire logic wt_clear,
  // Sequencer controls.
  input wire logic [UNITS-1:0] slot_sel,
  input wire logic [UNITS-1:0] unit_sel,
  input wire logic start,
  input wire logic [$clog2(WLEN):0] int_len,
  input wire logic disc_mode,
  input wire logic spectro_mode,
  input wire logic signed [AW-1:0] threshold,
  // Input samples.
  input wire logic in_valid,
  input wire logic signed [SW-1:0] in_re,
  input wire logic signed [SW-1:0] in_im,
  // Outputs.
  output logic signed [SW+4:0] out_re,
  output logic signed [SW+4:0] out_im,
  output logic busy,
  output logic done,
  output logic [UNITS-1:0] state_bits,
  output logic [UNITS-1:0] pair_bits,
  output logic [2*AW-1:0] psd
);
  // Storage is small per slot: one complex value per waveform slot.
  // A longer waveform store belongs to the sequencer memory outside.
  logic signed [SW-1:0] wv_re_reg [UNITS];
  logic signed [SW-1:0] wv_im_reg [UNITS];
  // Weight store, one full-length complex sequence per unit.
  logic signed [SW-1:0] wt_re_mem [UNITS][WLEN];
  logic signed [SW-1:0] wt_im_mem [UNITS][WLEN];
  // Per-unit complex accumulators.
  logic signed [AW-1:0] acc_re_reg [UNITS];
  logic signed [AW-1:0] acc_im_reg [UNITS];
  // Count of valid samples taken in the current readout.
  logic [$clog2(WLEN):0] cnt_reg, cnt_next;
  // Readout state.
  mri_state_t st_reg, st_next;
  // Combinational sum of the selected slots, five guard bits wide.
  logic signed [SW+4:0] sum_re, sum_im;
  // Decisions and spectrum prepared for the result registers.
  logic [UNITS-1:0] state_next, pair_next;
  logic [2*AW-1:0] psd_reg, psd_next;
  // Totals of the selected accumulators for the spectrum.
  logic signed [AW-1:0] tot_re, tot_im;

  // Only the two documented bank sizes are supported.
  initial
  begin
    if (UNITS != 8 && UNITS != 16)
      $error("UNITS must be 8 or 16");
    if (WLEN != MRI_WEIGHT_LEN)
      $error("WLEN must match the weight length");
  end

  // Waveform slots: write stores, clear erases all at once.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < UNITS; i++)
      begin
        wv_re_reg[i] <= '0;
        wv_im_reg[i] <= '0;
      end
    end
    else if (clk_en)
    begin
      for (int i = 0; i < UNITS; i++)
      begin
        if (wave_clear)
        begin
          wv_re_reg[i] <= '0;
          wv_im_reg[i] <= '0;
        end
        else if (wave_wr && wave_slot == i[$clog2(UNITS)-1:0])
        begin
          wv_re_reg[i] <= wave_re;
          wv_im_reg[i] <= wave_im;
        end
      end
    end
  end

  // Weight memory: no reset, so clear zero-fills, and unwritten samples
  // stay zero, which extends any upload to the full length.
  // Clearing every sample in one cycle costs a wide write fan-out; the
  // trade buys a clear that needs no sequencing and no busy flag.
  always_ff @(posedge clk)
  begin
    if (clk_en)
    begin
      for (int u = 0; u < UNITS; u++)
      begin
        for (int a = 0; a < WLEN; a++)
        begin
          if (wt_clear)
          begin
            wt_re_mem[u][a] <= '0;
            wt_im_mem[u][a] <= '0;
          end
          else if (wt_wr && wt_unit == u[$clog2(UNITS)-1:0]
                   && wt_addr == a[$clog2(WLEN)-1:0])
          begin
            wt_re_mem[u][a] <= wt_re;
            wt_im_mem[u][a] <= wt_im;
          end
        end
      end
    end
  end

  // Sum of selected slots forms the output stream.
  // The adder chain is unrolled; with sixteen slots it is the longest path.
  always_comb
  begin
    sum_re = '0;
    sum_im = '0;
    for (int i = 0; i < UNITS; i++)
    begin
      if (slot_sel[i])
      begin
        sum_re = sum_re + (SW+5)'(wv_re_reg[i]);
        sum_im = sum_im + (SW+5)'(wv_im_reg[i]);
      end
    end
  end

  // Output stream registers; saturation is the host's job.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_re <= '0;
      out_im <= '0;
    end
    else if (clk_en)
    begin
      // No saturation here: the host keeps the summed amplitude within
      // full scale, and the guard bits hold the sum of all slots anyway.
      out_re <= sum_re;
      out_im <= sum_im;
    end
  end

  // Sequencing: start clears, count to int_len, then finish.
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      MRI_IDLE:
      begin
        if (start)
        begin
          st_next = MRI_RUN;
          cnt_next = '0;
        end
      end
      MRI_RUN:
      begin
        // The run ends on the sample that reaches the length.
        if (in_valid)
          cnt_next = cnt_reg + 1'b1;
        if (in_valid && cnt_reg + 1'b1 >= int_len)
          st_next = MRI_DONE;
      end
      default:
        st_next = MRI_IDLE;
    endcase
  end

  // State and sample count only register here; the clock enable holds
  // a readout in place without losing its position.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg <= MRI_IDLE;
      cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
    end
  end

  // Multiply by conjugate weight and accumulate, one unit per generate.
  generate
    for (genvar g = 0; g < UNITS; g++)
    begin : g_unit
      logic signed [SW-1:0] w_re, w_im;
      logic signed [2*SW:0] p_re, p_im;
      assign w_re = wt_re_mem[g][cnt_reg[$clog2(WLEN)-1:0]];
      assign w_im = wt_im_mem[g][cnt_reg[$clog2(WLEN)-1:0]];
      // (a+jb)(c-jd) = ac+bd + j(bc-ad).
      assign p_re = (2*SW+1)'(in_re * w_re) + (2*SW+1)'(in_im * w_im);
      assign p_im = (2*SW+1)'(in_im * w_re) - (2*SW+1)'(in_re * w_im);
      // Start clears the sums even of units left out of this readout.
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          acc_re_reg[g] <= '0;
          acc_im_reg[g] <= '0;
        end
        else if (clk_en)
        begin
          if (st_reg == MRI_IDLE && start)
          begin
            acc_re_reg[g] <= '0;
            acc_im_reg[g] <= '0;
          end
          else if (st_reg == MRI_RUN && in_valid && unit_sel[g])
          begin
            acc_re_reg[g] <= acc_re_reg[g] + AW'(p_re);
            acc_im_reg[g] <= acc_im_reg[g] + AW'(p_im);
          end
        end
      end
    end
  endgenerate

  // Discrimination and PSD computed on the final accumulators.
  always_comb
  begin
    tot_re = '0;
    tot_im = '0;
    state_next = '0;
    pair_next = '0;
    for (int i = 0; i < UNITS; i++)
    begin
      // Two-state: one unit per qubit, real part against threshold.
      state_next[i] = unit_sel[i]
        && (acc_re_reg[i] > threshold);
      tot_re = tot_re + (unit_sel[i] ? acc_re_reg[i] : '0);
      tot_im = tot_im + (unit_sel[i] ? acc_im_reg[i] : '0);
    end
    // Multistate: derived pair (i,i+1) from the real accumulators' difference.
    if (disc_mode == MRI_MULTI_STATE)
    begin
      // Only neighbouring pairs are formed; wider pairs are left to software.
      for (int i = 0; i < UNITS - 1; i++)
        pair_next[i] =
          (acc_re_reg[i+1] - acc_re_reg[i]) > threshold;
    end
  end

  // Result registers update once per finished readout.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_bits <= '0;
      pair_bits <= '0;
      psd_reg <= '0;
    end
    else if (clk_en && st_reg == MRI_DONE)
    begin
      state_bits <= state_next;
      pair_bits <= pair_next;
      psd_reg <= psd_next;
    end
  end

  // Squared magnitude of the summed selected accumulators; scaling to Vrms^2/Hz is
  // applied by software using the integration length.
  always_comb
  begin
    psd_next = psd_reg;
    if (spectro_mode)
      psd_next = (2*AW)'(tot_re * tot_re)
        + (2*AW)'(tot_im * tot_im);
  end

  // Results come from registers; busy and done decode the state register
  // directly, so done stands for the finishing state, held until the next edge with clk_en high.
  assign psd = psd_reg;
  assign busy = (st_reg == MRI_RUN);
  assign done = (st_reg == MRI_DONE);
endmodule : mri_integrator

/* testbench/mri_integrator_checker.sv */
// Checker of readout timing and result updates.
`timescale 1ns/10ps
module mri_integrator_checker
  import mri_pkg::*;
#(parameter int UNITS = MRI_UNITS)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic disc_mode,
  input wire logic spectro_mode,
  input wire logic [UNITS-1:0] unit_sel,
  input wire logic busy,
  input wire logic done,
  input wire logic [UNITS-1:0] state_bits,
  input wire logic [UNITS-1:0] pair_bits,
  input wire logic [2*MRI_ACC_W-1:0] psd
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Launch from idle; done and busy both low mark idle.
  sequence s_go;
    start && clk_en && !busy && !done;
  endsequence
  // One done cycle, then back to idle.
  sequence s_end;
    done ##1 (!done && !busy);
  endsequence
  a_start_runs: assert property (s_go |=> busy)
    else $error("start in idle left busy low");
  a_done_once: assert property (done && clk_en |-> s_end)
    else $error("done is not a single pulse");
  a_busy_ends: assert property ($fell(busy) |-> done)
    else $error("busy fell without done");
  a_done_run: assert property ($rose(done) |-> $past(busy))
    else $error("done without a run");
  a_pair_two: assert property
    (done && disc_mode == MRI_TWO_STATE |=> pair_bits == '0)
    else $error("pair bits set in two-state mode");
  a_unsel_clear: assert property
    (done |=> (state_bits & ~$past(unit_sel)) == '0)
    else $error("state bit of an unused unit");
  a_state_hold: assert property (!done |=> $stable(state_bits))
    else $error("state bits moved without done");
  a_psd_hold: assert property
    (!(done && spectro_mode) |=> $stable(psd))
    else $error("psd moved outside spectroscopy");
endmodule : mri_integrator_checker

/* testbench/mri_adc_model.sv */
// Model of the converter that feeds complex samples.
`timescale 1ns/10ps
module mri_adc_model
(
  input wire logic clk,
  input wire logic run,
  output logic in_valid,
  output logic signed [15:0] in_re,
  output logic signed [15:0] in_im
);
  initial {in_valid, in_re, in_im} = '0;
  // Bursts with gaps; idle lines show the inverse so stale data shows up.
  always @(posedge clk)
    if (run && $urandom_range(3) != 0)
    begin
      in_valid <= 1'b1;
      in_re <= 16'(int'($urandom_range(4095)) - 2048);
      in_im <= 16'(int'($urandom_range(4095)) - 2048);
    end
    else
    begin
      in_valid <= 1'b0;
      in_re <= ~in_re;
      in_im <= ~in_im;
    end
endmodule : mri_adc_model

/* testbench/mri_integrator_tb.sv */
// Self-checking bench of the readout integrator.
`timescale 1ns/10ps
module mri_integrator_tb;
  import mri_pkg::*;
  localparam int L = 8; // Short integration keeps the run brief.
  logic clk = 0, reset_n = 0, run = 0, start = 0, disc_mode = 0;
  logic wave_wr = 0, wave_clear = 0, wt_wr = 0, wt_clear = 0;
  logic spectro_mode = 0, clk_en = 1, in_valid, busy, done;
  logic [3:0] wave_slot = 0, wt_unit = 0;
  logic [11:0] wt_addr = 0;
  logic [12:0] int_len = 13'(L);
  logic [15:0] slot_sel = 0, unit_sel = 0, state_bits, pair_bits;
  logic signed [15:0] wave_re = 0, wave_im = 0, wt_re = 0, wt_im = 0;
  logic signed [15:0] in_re, in_im, s_re [16], s_im [16];
  logic signed [15:0] w_re [2][L], w_im [2][L];
  logic signed [20:0] out_re, out_im;
  logic signed [47:0] threshold = 0, a_re [2], a_im [2];
  logic signed [95:0] sr, si;
  logic [95:0] psd, e_psd = 0;
  int errors = 0, n_checks = 0, k;
  always #5 clk = ~clk;
  mri_integrator i_dut (.clk, .reset_n, .clk_en, .wave_wr, .wave_slot,
    .wave_re, .wave_im, .wave_clear, .wt_wr, .wt_unit, .wt_addr, .wt_re,
    .wt_im, .wt_clear, .slot_sel, .unit_sel, .start, .int_len, .disc_mode,
    .spectro_mode, .threshold, .in_valid, .in_re, .in_im, .out_re, .out_im,
    .busy, .done, .state_bits, .pair_bits, .psd);
  mri_adc_model i_adc (.clk, .run, .in_valid, .in_re, .in_im);
  task automatic check(input logic [95:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic end_of_test;
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  // Expected sum of the selected slots, real or imaginary part.
  function automatic logic signed [20:0] sum_of(logic [15:0] m, bit re);
    sum_of = 0;
    for (int s = 0; s < 16; s++)
      if (m[s])
        sum_of += re ? s_re[s] : s_im[s];
  endfunction : sum_of
  // Conjugate products of every sample taken while the run is on.
  always @(posedge clk)
    if (busy && in_valid && k < L)
    begin
      for (int u = 0; u < 2; u++)
      begin
        a_re[u] <= a_re[u] + in_re * w_re[u][k] + in_im * w_im[u][k];
        a_im[u] <= a_im[u] + in_im * w_re[u][k] - in_re * w_im[u][k];
      end
      k <= k + 1;
    end
  // A hang ends the run as a mismatch.
  initial
  begin
    #50000;
    errors++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'hCD6612D4));
    tick(6);
    reset_n <= 1'b1;
    tick();
    check(96'({busy, done, state_bits, pair_bits}), '0);
    check(psd, '0);
    wave_clear <= 1'b1;
    wt_clear <= 1'b1;
    for (int s = 0; s < 16; s++)
    begin
      tick();
      {wave_clear, wt_clear, wave_wr, wave_slot} <= {3'h1, 4'(s)};
      // Each slot stays within 1/16 of full scale, so any sum fits.
      s_re[s] = 16'(int'($urandom_range(4095)) - 2048);
      s_im[s] = 16'(int'($urandom_range(4095)) - 2048);
      {wave_re, wave_im} <= {s_re[s], s_im[s]};
    end
    for (int r = 0; r < 5; r++)
    begin
      tick();
      wave_wr <= 1'b0;
      slot_sel <= r == 0 ? 16'hFFFF : 16'($urandom);
      tick(3);
      check(out_re, sum_of(slot_sel, 1));
      check(out_im, sum_of(slot_sel, 0));
    end
    // Clock enable low freezes the output stream on a new selection.
    clk_en <= 1'b0;
    slot_sel <= ~slot_sel;
    tick(3);
    check(out_re, sum_of(~slot_sel, 1));
    clk_en <= 1'b1;
    tick(2);
    check(out_re, sum_of(slot_sel, 1));
    wave_clear <= 1'b1;
    tick();
    wave_clear <= 1'b0;
    tick(3);
    check(96'({out_re, out_im}), '0);
    for (int i = 0; i < 2 * L; i++)
    begin
      // The real part of the first sample of each unit is a full-scale peak.
      w_re[i/L][i%L] = i % L == 0 ? 16'sh7FFF
        : 16'(int'($urandom_range(4095)) - 2048);
      w_im[i/L][i%L] = 16'(int'($urandom_range(4095)) - 2048);
      {wt_wr, wt_unit, wt_addr} <= {1'b1, 4'(i / L), 12'(i % L)};
      {wt_re, wt_im} <= {w_re[i/L][i%L], w_im[i/L][i%L]};
      tick();
    end
    wt_wr <= 1'b0;
    // Modes: two-state, multistate, two-state, one unit only.
    for (int m = 0; m < 4; m++)
    begin
      tick();
      {disc_mode, spectro_mode} <= {m == 1, m != 1};
      unit_sel <= m == 3 ? 16'h1 : 16'h3;
      threshold <= 48'($urandom_range(33554431));
      {a_re[0], a_re[1], a_im[0], a_im[1], k} = '0;
      start <= 1'b1;
      tick();
      {start, run} <= 2'h1;
      for (int t = 0; t < 200 && done !== 1'b1; t++)
        tick();
      check(done, 1'b1);
      run <= 1'b0;
      tick(2);
      sr = unit_sel[1] ? a_re[0] + a_re[1] : a_re[0];
      si = unit_sel[1] ? a_im[0] + a_im[1] : a_im[0];
      // One readout per spectrum point; the host averages many of them
      // and keeps its frequency step within the 1/L bandwidth.
      if (spectro_mode)
        e_psd = sr * sr + si * si;
      check(psd, e_psd);
      if (!disc_mode)
        check(state_bits, {unit_sel[1] && a_re[1] > threshold,
          a_re[0] > threshold});
      check(pair_bits, {disc_mode && -a_re[1] > threshold,
        disc_mode && a_re[1] - a_re[0] > threshold});
    end
    end_of_test();
  end
endmodule : mri_integrator_tb
bind mri_integrator mri_integrator_checker #(.UNITS(UNITS)) i_chk (.clk,
  .reset_n, .clk_en, .start, .disc_mode, .spectro_mode, .unit_sel, .busy,
  .done, .state_bits, .pair_bits, .psd);
